// file: msio_regs.vh
/*
 * Constants of the motion synchronisation unit: APB register offsets,
 * command codes, flag bit positions, reset values and timing counts.
 * Assumes a 10 MHz pclk and 32-bit APB data, one register per word.
 */
`ifndef MSIO_REGS_VH
`define MSIO_REGS_VH

// Register byte offsets
`define MSIO_OFS_IN_FLAGS     8'h00
`define MSIO_OFS_DEAD_TIME    8'h04
`define MSIO_OFS_TARGET_POS   8'h08
`define MSIO_OFS_TARGET_USTEP 8'h0C
`define MSIO_OFS_SPEED        8'h10
`define MSIO_OFS_SPEED_USTEP  8'h14
`define MSIO_OFS_OUT_FLAGS    8'h18
`define MSIO_OFS_PULSE_LEN    8'h1C
`define MSIO_OFS_PULSE_IVL    8'h20
`define MSIO_OFS_WINDOW       8'h24
`define MSIO_OFS_WINDOW_USTEP 8'h28
`define MSIO_OFS_COMMAND      8'h2C
`define MSIO_OFS_CHECKSUM     8'h30
`define MSIO_OFS_STATUS       8'h34

// Command codes
`define MSIO_CMD_SET_IN       32'h696E_7373
`define MSIO_CMD_SET_OUT      32'h6F6E_7373

// Input flag bit positions
`define MSIO_IN_ON            0
`define MSIO_IN_FALLING       1
`define MSIO_IN_ABSOLUTE      2

// Output flag bit positions
`define MSIO_OUT_AUTO         0
`define MSIO_OUT_FIXED_LEVEL  1
`define MSIO_OUT_ACTIVE_LOW   2
`define MSIO_OUT_LEN_COUNTS   3
`define MSIO_OUT_ON_START     4
`define MSIO_OUT_ON_STOP      5
`define MSIO_OUT_PERIODIC     6

// Status bit positions
`define MSIO_ST_IN_OK         0
`define MSIO_ST_IN_ERR        1
`define MSIO_ST_OUT_OK        2
`define MSIO_ST_OUT_ERR       3
`define MSIO_ST_PIN           4
`define MSIO_ST_DEAD          5
`define MSIO_ST_PULSE         6
`define MSIO_ST_REACHED       7

// Reset value of every settings register
`define MSIO_RST_VALUE        32'h0000_0000

// Timing: one microsecond in pclk cycles, rounded up
`define MSIO_CLK_PERIOD_NS    100
`define MSIO_US_NS            1000
`define MSIO_US_CYCLES ((`MSIO_US_NS + `MSIO_CLK_PERIOD_NS - 1) / `MSIO_CLK_PERIOD_NS)
`define MSIO_PRE_W            4

`endif

// file: msio_top.v
/*
 * Motion synchronisation unit: trigger input that launches a move and a
 * synchronisation output pin that is fixed or pulsed on motion events.
 * Settings are staged over APB and applied by a command word with a
 * checksum. Assumes the motion core shares pclk and gives one-cycle
 * pulses for move start, move stop and each step or encoder pulse.
 */
`timescale 1ns/100ps
`include "msio_regs.vh"

// Contract
// RULE1 - Trigger pin acts only while input flag bit 0x1 is set.
// RULE2 - Input flag bit 0x2 selects falling edge, else rising edge.
// RULE3 - Input flag bit 0x4 selects absolute target, else relative shift.
// RULE4 - A 16-bit dead time in microseconds masks pulses after an accepted one.
// RULE5 - Move target holds a signed 32-bit whole-step part.
// RULE6 - Move target holds a signed 16-bit microstep part, stepper only.
// RULE7 - Move runs at a 32-bit unsigned target speed.
// RULE8 - An 8-bit microstep speed part is added for steppers.
// RULE9 - Input settings command code stores the staged input settings.
// RULE10 - Output settings command code stores the staged output settings.
// RULE11 - Output flag bit 0x1 lets pulse logic drive the pin.
// RULE12 - With pulse logic off the pin follows output flag bit 0x2.
// RULE13 - Output flag bit 0x4 makes low the active pulse level.
// RULE14 - Output flag bit 0x8 counts pulse length in steps, not time.
// RULE15 - Pulses at move start with bit 0x10, at move stop with 0x20.
// RULE16 - Output flag bit 0x40 gives a pulse every programmed step count.
// RULE17 - Pulse lasts a 16-bit length in microseconds or in steps.
// RULE18 - Periodic pulses are spaced by a 16-bit step count.
// RULE19 - Stop pulse needs position inside the whole and microstep window.
// RULE20 - A settings command with a wrong checksum changes nothing; the code still updates its ok and error status bits.
// RULE21 - Trigger pin is synchronised before edge detection and dead time.
module msio_top (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Trigger pin
  input  wire        trig_in,
  // Motion core status
  input  wire        move_started,
  input  wire        move_stopped,
  input  wire        step_tick,
  input  wire [31:0] cur_pos,
  input  wire [15:0] cur_ustep,
  // Move request
  output wire        move_req,
  output wire        move_absolute,
  output wire [31:0] move_pos,
  output wire [15:0] move_ustep,
  output wire [31:0] move_speed,
  output wire [7:0]  move_speed_ustep,
  // Synchronisation pin
  output wire        sync_out
);

  localparam integer US_LAST_I = `MSIO_US_CYCLES - 1;
  localparam [`MSIO_PRE_W-1:0] US_LAST = US_LAST_I[`MSIO_PRE_W-1:0];

  function [15:0] fold;
    input [31:0] w;
    begin
      fold = w[31:16] ^ w[15:0];
    end
  endfunction

  // Staged settings, written by software
  reg [7:0]  st_in_flags_ff;
  reg [15:0] st_dead_ff;
  reg [31:0] st_pos_ff;
  reg [15:0] st_ustep_ff;
  reg [31:0] st_speed_ff;
  reg [7:0]  st_spd_u_ff;
  reg [7:0]  st_out_flags_ff;
  reg [15:0] st_len_ff;
  reg [15:0] st_ivl_ff;
  reg [31:0] st_win_ff;
  reg [7:0]  st_win_u_ff;
  reg [15:0] st_sum_ff;

  // Applied settings, steering the logic
  reg [7:0]  trig_in_flags_ff;
  reg [15:0] trig_dead_time_ff;
  reg [31:0] target_pos_ff;
  reg [15:0] target_microstep_part_ff;
  reg [31:0] target_speed_ff;
  reg [7:0]  speed_microstep_part_ff;
  reg [7:0]  pulse_out_flags_ff;
  reg [15:0] pulse_length_ff;
  reg [15:0] pulse_interval_ff;
  reg [31:0] window_ff;
  reg [7:0]  window_microstep_part_ff;

  // Command results
  reg        in_ok_ff;
  reg        in_err_ff;
  reg        out_ok_ff;
  reg        out_err_ff;

  // APB read path
  reg [31:0] prdata_ff;
  reg        pslverr_ff;
  reg [31:0] nxt_rdata;
  reg        nxt_unmapped;

  // Trigger path
  reg        trig_s1_ff;
  reg        trig_s2_ff;
  reg        trig_prev_ff;
  reg [15:0] dead_left_ff;
  reg [`MSIO_PRE_W-1:0] dead_pre_ff;

  // Move request outputs
  reg        move_req_ff;
  reg        move_abs_ff;
  reg [31:0] move_pos_ff;
  reg [15:0] move_ustep_ff;
  reg [31:0] move_speed_ff;
  reg [7:0]  move_spd_u_ff;

  // Output pulse generator
  reg [15:0] pulse_left_ff;
  reg [`MSIO_PRE_W-1:0] pulse_pre_ff;
  reg [15:0] ivl_cnt_ff;
  reg        sync_out_ff;

  wire       wr_en;
  wire       cmd_wr;
  wire [15:0] in_sum;
  wire [15:0] out_sum;
  wire       trig_edge;
  wire       dead_active;
  wire       trig_accept;
  wire [31:0] pos_diff;
  wire [31:0] pos_abs;
  wire [15:0] u_diff;
  wire [15:0] u_abs;
  wire       reached;
  wire       periodic_fire;
  wire       pulse_fire;
  wire       pulse_active;
  wire       pulse_tick;
  wire       nxt_pin;

  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;
  assign wr_en   = psel & penable & pwrite;
  assign cmd_wr  = wr_en & (paddr == `MSIO_OFS_COMMAND);

  // Each group is checked against the XOR fold of its own staged fields
  assign in_sum = fold({24'h00_0000, st_in_flags_ff}) ^ fold({16'h0000, st_dead_ff}) ^
                  fold(st_pos_ff) ^ fold({16'h0000, st_ustep_ff}) ^
                  fold(st_speed_ff) ^ fold({24'h00_0000, st_spd_u_ff});
  assign out_sum = fold({24'h00_0000, st_out_flags_ff}) ^ fold({16'h0000, st_len_ff}) ^
                   fold({16'h0000, st_ivl_ff}) ^ fold(st_win_ff) ^
                   fold({24'h00_0000, st_win_u_ff});

  // Staged settings and checksum
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_in_flags_ff  <= 8'h00;
      st_dead_ff      <= 16'h0000;
      st_pos_ff       <= `MSIO_RST_VALUE;
      st_ustep_ff     <= 16'h0000;
      st_speed_ff     <= `MSIO_RST_VALUE;
      st_spd_u_ff     <= 8'h00;
      st_out_flags_ff <= 8'h00;
      st_len_ff       <= 16'h0000;
      st_ivl_ff       <= 16'h0000;
      st_win_ff       <= `MSIO_RST_VALUE;
      st_win_u_ff     <= 8'h00;
      st_sum_ff       <= 16'h0000;
    end else if (wr_en) begin
      case (paddr)
        `MSIO_OFS_IN_FLAGS:     st_in_flags_ff  <= pwdata[7:0];
        `MSIO_OFS_DEAD_TIME:    st_dead_ff      <= pwdata[15:0];
        `MSIO_OFS_TARGET_POS:   st_pos_ff       <= pwdata;
        `MSIO_OFS_TARGET_USTEP: st_ustep_ff     <= pwdata[15:0];
        `MSIO_OFS_SPEED:        st_speed_ff     <= pwdata;
        `MSIO_OFS_SPEED_USTEP:  st_spd_u_ff     <= pwdata[7:0];
        `MSIO_OFS_OUT_FLAGS:    st_out_flags_ff <= pwdata[7:0];
        `MSIO_OFS_PULSE_LEN:    st_len_ff       <= pwdata[15:0];
        `MSIO_OFS_PULSE_IVL:    st_ivl_ff       <= pwdata[15:0];
        `MSIO_OFS_WINDOW:       st_win_ff       <= pwdata;
        `MSIO_OFS_WINDOW_USTEP: st_win_u_ff     <= pwdata[7:0];
        `MSIO_OFS_CHECKSUM:     st_sum_ff       <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Applying a command: only a matching checksum replaces the settings
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_in_flags_ff         <= 8'h00;
      trig_dead_time_ff        <= 16'h0000;
      target_pos_ff            <= `MSIO_RST_VALUE;
      target_microstep_part_ff <= 16'h0000;
      target_speed_ff          <= `MSIO_RST_VALUE;
      speed_microstep_part_ff  <= 8'h00;
      pulse_out_flags_ff       <= 8'h00;
      pulse_length_ff          <= 16'h0000;
      pulse_interval_ff        <= 16'h0000;
      window_ff                <= `MSIO_RST_VALUE;
      window_microstep_part_ff <= 8'h00;
      in_ok_ff                 <= 1'b0;
      in_err_ff                <= 1'b0;
      out_ok_ff                <= 1'b0;
      out_err_ff               <= 1'b0;
    end else if (cmd_wr && pwdata == `MSIO_CMD_SET_IN) begin
      in_ok_ff  <= (in_sum == st_sum_ff);
      in_err_ff <= (in_sum != st_sum_ff);                    // RULE20
      if (in_sum == st_sum_ff) begin                         // RULE20
        trig_in_flags_ff         <= st_in_flags_ff;          // RULE9
        trig_dead_time_ff        <= st_dead_ff;              // RULE9
        target_pos_ff            <= st_pos_ff;               // RULE5
        target_microstep_part_ff <= st_ustep_ff;             // RULE6
        target_speed_ff          <= st_speed_ff;             // RULE7
        speed_microstep_part_ff  <= st_spd_u_ff;             // RULE8
      end
    end else if (cmd_wr && pwdata == `MSIO_CMD_SET_OUT) begin
      out_ok_ff  <= (out_sum == st_sum_ff);
      out_err_ff <= (out_sum != st_sum_ff);                  // RULE20
      if (out_sum == st_sum_ff) begin                        // RULE20
        pulse_out_flags_ff       <= st_out_flags_ff;         // RULE10
        pulse_length_ff          <= st_len_ff;               // RULE10
        pulse_interval_ff        <= st_ivl_ff;               // RULE10
        window_ff                <= st_win_ff;               // RULE19
        window_microstep_part_ff <= st_win_u_ff;             // RULE19
      end
    end
  end

  // Read data is prepared in the setup phase so the access phase needs no wait
  always @* begin
    nxt_rdata    = 32'h0000_0000;
    nxt_unmapped = 1'b0;
    case (paddr)
      `MSIO_OFS_IN_FLAGS:     nxt_rdata = {24'h00_0000, st_in_flags_ff};
      `MSIO_OFS_DEAD_TIME:    nxt_rdata = {16'h0000, st_dead_ff};
      `MSIO_OFS_TARGET_POS:   nxt_rdata = st_pos_ff;
      `MSIO_OFS_TARGET_USTEP: nxt_rdata = {16'h0000, st_ustep_ff};
      `MSIO_OFS_SPEED:        nxt_rdata = st_speed_ff;
      `MSIO_OFS_SPEED_USTEP:  nxt_rdata = {24'h00_0000, st_spd_u_ff};
      `MSIO_OFS_OUT_FLAGS:    nxt_rdata = {24'h00_0000, st_out_flags_ff};
      `MSIO_OFS_PULSE_LEN:    nxt_rdata = {16'h0000, st_len_ff};
      `MSIO_OFS_PULSE_IVL:    nxt_rdata = {16'h0000, st_ivl_ff};
      `MSIO_OFS_WINDOW:       nxt_rdata = st_win_ff;
      `MSIO_OFS_WINDOW_USTEP: nxt_rdata = {24'h00_0000, st_win_u_ff};
      `MSIO_OFS_COMMAND:      nxt_rdata = 32'h0000_0000;
      `MSIO_OFS_CHECKSUM:     nxt_rdata = {16'h0000, st_sum_ff};
      `MSIO_OFS_STATUS: begin
        nxt_rdata[`MSIO_ST_IN_OK]   = in_ok_ff;
        nxt_rdata[`MSIO_ST_IN_ERR]  = in_err_ff;
        nxt_rdata[`MSIO_ST_OUT_OK]  = out_ok_ff;
        nxt_rdata[`MSIO_ST_OUT_ERR] = out_err_ff;
        nxt_rdata[`MSIO_ST_PIN]     = sync_out_ff;
        nxt_rdata[`MSIO_ST_DEAD]    = dead_active;
        nxt_rdata[`MSIO_ST_PULSE]   = pulse_active;
        nxt_rdata[`MSIO_ST_REACHED] = reached;
      end
      default: nxt_unmapped = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_rdata;
      pslverr_ff <= nxt_unmapped;
    end
  end

  // Trigger pin: two-stage synchroniser, then edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1_ff   <= 1'b0;
      trig_s2_ff   <= 1'b0;
      trig_prev_ff <= 1'b0;
    end else begin
      trig_s1_ff   <= trig_in;                               // RULE21
      trig_s2_ff   <= trig_s1_ff;                            // RULE21
      trig_prev_ff <= trig_s2_ff;
    end
  end

  assign trig_edge = trig_in_flags_ff[`MSIO_IN_FALLING] ?
                     (trig_prev_ff & ~trig_s2_ff) :          // RULE2
                     (~trig_prev_ff & trig_s2_ff);           // RULE2
  assign dead_active = (dead_left_ff != 16'h0000);
  assign trig_accept = trig_in_flags_ff[`MSIO_IN_ON] & trig_edge & ~dead_active; // RULE1

  // Dead time counts whole microseconds after each accepted trigger
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dead_left_ff <= 16'h0000;
      dead_pre_ff  <= {`MSIO_PRE_W{1'b0}};
    end else if (trig_accept) begin
      dead_left_ff <= trig_dead_time_ff;                     // RULE4
      dead_pre_ff  <= {`MSIO_PRE_W{1'b0}};
    end else if (dead_active) begin
      if (dead_pre_ff == US_LAST) begin
        dead_pre_ff  <= {`MSIO_PRE_W{1'b0}};
        dead_left_ff <= dead_left_ff - 16'h0001;             // RULE4
      end else begin
        dead_pre_ff  <= dead_pre_ff + 1'b1;
      end
    end
  end

  // Move request; a shift is turned into an absolute target here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      move_req_ff   <= 1'b0;
      move_abs_ff   <= 1'b0;
      move_pos_ff   <= 32'h0000_0000;
      move_ustep_ff <= 16'h0000;
      move_speed_ff <= 32'h0000_0000;
      move_spd_u_ff <= 8'h00;
    end else begin
      move_req_ff <= trig_accept;
      if (trig_accept) begin
        move_abs_ff   <= trig_in_flags_ff[`MSIO_IN_ABSOLUTE];
        if (trig_in_flags_ff[`MSIO_IN_ABSOLUTE]) begin         // RULE3
          move_pos_ff   <= target_pos_ff;                      // RULE5
          move_ustep_ff <= target_microstep_part_ff;           // RULE6
        end else begin
          move_pos_ff   <= cur_pos + target_pos_ff;            // RULE3
          move_ustep_ff <= cur_ustep + target_microstep_part_ff; // RULE3
        end
        move_speed_ff <= target_speed_ff;                      // RULE7
        move_spd_u_ff <= speed_microstep_part_ff;              // RULE8
      end
    end
  end

  assign move_req         = move_req_ff;
  assign move_absolute    = move_abs_ff;
  assign move_pos         = move_pos_ff;
  assign move_ustep       = move_ustep_ff;
  assign move_speed       = move_speed_ff;
  assign move_speed_ustep = move_spd_u_ff;

  // Target window around the last triggered target
  assign pos_diff = cur_pos - move_pos_ff;
  assign pos_abs  = pos_diff[31] ? (32'h0000_0000 - pos_diff) : pos_diff;
  assign u_diff   = cur_ustep - move_ustep_ff;
  assign u_abs    = u_diff[15] ? (16'h0000 - u_diff) : u_diff;
  assign reached  = (pos_abs < window_ff) ||
                    ((pos_abs == window_ff) &&
                     (u_abs <= {8'h00, window_microstep_part_ff})); // RULE19

  // Periodic pulses counted on step or encoder ticks
  assign periodic_fire = pulse_out_flags_ff[`MSIO_OUT_PERIODIC] & step_tick &
                         (pulse_interval_ff != 16'h0000) &
                         (ivl_cnt_ff == pulse_interval_ff - 16'h0001); // RULE18

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ivl_cnt_ff <= 16'h0000;
    end else if (!pulse_out_flags_ff[`MSIO_OUT_PERIODIC]) begin
      ivl_cnt_ff <= 16'h0000;
    end else if (step_tick) begin
      if (periodic_fire) begin
        ivl_cnt_ff <= 16'h0000;                              // RULE16
      end else begin
        ivl_cnt_ff <= ivl_cnt_ff + 16'h0001;                 // RULE18
      end
    end
  end

  assign pulse_fire =
    (pulse_out_flags_ff[`MSIO_OUT_ON_START] & move_started) |            // RULE15
    (pulse_out_flags_ff[`MSIO_OUT_ON_STOP] & move_stopped & reached) |   // RULE15
    periodic_fire;                                                       // RULE16
  assign pulse_active = (pulse_left_ff != 16'h0000);
  assign pulse_tick   = pulse_out_flags_ff[`MSIO_OUT_LEN_COUNTS] ?
                        step_tick : (pulse_pre_ff == US_LAST);           // RULE14

  // A new event while a pulse is running restarts its length
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_left_ff <= 16'h0000;
      pulse_pre_ff  <= {`MSIO_PRE_W{1'b0}};
    end else if (pulse_fire) begin
      pulse_left_ff <= pulse_length_ff;                      // RULE17
      pulse_pre_ff  <= {`MSIO_PRE_W{1'b0}};
    end else if (pulse_active) begin
      pulse_pre_ff <= (pulse_pre_ff == US_LAST) ? {`MSIO_PRE_W{1'b0}} :
                      pulse_pre_ff + 1'b1;
      if (pulse_tick) begin
        pulse_left_ff <= pulse_left_ff - 16'h0001;           // RULE17
      end
    end
  end

  assign nxt_pin = pulse_out_flags_ff[`MSIO_OUT_AUTO] ?                  // RULE11
                   (pulse_active ^ pulse_out_flags_ff[`MSIO_OUT_ACTIVE_LOW]) : // RULE13
                   pulse_out_flags_ff[`MSIO_OUT_FIXED_LEVEL];            // RULE12

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out_ff <= 1'b0;
    end else begin
      sync_out_ff <= nxt_pin;
    end
  end

  assign sync_out = sync_out_ff;

endmodule // msio_top

// file: msio_monitor.sv
/*
 * Port checker for msio_top: APB answer timing and move request launch.
 * Assumes one pclk domain and the bind at the foot of this file.
 */
`timescale 1ns/100ps
module msio_monitor (
  // APB
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // Trigger and move request
  input logic        trig_in,
  input logic        move_req,
  input logic        move_absolute,
  input logic [31:0] move_pos,
  input logic [15:0] move_ustep,
  input logic [31:0] move_speed,
  input logic [7:0]  move_speed_ustep
);
  logic [3:0] since_chg_ff;
  logic       pin_q_ff;

  // Saturating age of the last pin change, so a stray request stands out
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_chg_ff <= 4'hF;
      pin_q_ff     <= 1'b0;
    end else begin
      pin_q_ff <= trig_in;
      if (trig_in != pin_q_ff)
        since_chg_ff <= 4'h0;
      else if (since_chg_ff != 4'hF)
        since_chg_ff <= since_chg_ff + 4'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup_access;
    psel && !penable ##1 psel && penable;
  endsequence

  property p_ready_high;
    pready;
  endproperty
  property p_read_hold;
    s_setup_access |=> $stable(prdata) && $stable(pslverr);
  endproperty
  property p_req_single;
    move_req |=> !move_req;
  endproperty
  property p_req_after_pin;
    move_req |-> since_chg_ff >= 4'h1 && since_chg_ff <= 4'h5;
  endproperty
  property p_abs_hold;
    !move_req |-> $stable(move_absolute);
  endproperty
  property p_pos_hold;
    !move_req |-> $stable(move_pos);
  endproperty
  property p_ustep_hold;
    !move_req |-> $stable(move_ustep);
  endproperty
  property p_speed_hold;
    !move_req |-> $stable(move_speed);
  endproperty
  property p_speed_ustep_hold;
    !move_req |-> $stable(move_speed_ustep);
  endproperty

  a_ready_high: assert property (p_ready_high)
    else $error("pready not high");
  a_read_hold: assert property (p_read_hold)
    else $error("read answer moved after access");
  a_req_single: assert property (p_req_single)
    else $error("move request longer than one cycle");
  a_req_after_pin: assert property (p_req_after_pin)
    else $error("move request not tied to a recent pin edge");
  a_abs_hold: assert property (p_abs_hold)
    else $error("move mode changed without request");
  a_pos_hold: assert property (p_pos_hold)
    else $error("move position changed without request");
  a_ustep_hold: assert property (p_ustep_hold)
    else $error("move microsteps changed without request");
  a_speed_hold: assert property (p_speed_hold)
    else $error("move speed changed without request");
  a_speed_ustep_hold: assert property (p_speed_ustep_hold)
    else $error("move speed microsteps changed without request");
endmodule // msio_monitor

bind msio_top msio_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_in(trig_in),
  .move_req(move_req), .move_absolute(move_absolute), .move_pos(move_pos),
  .move_ustep(move_ustep), .move_speed(move_speed), .move_speed_ustep(move_speed_ustep)
);

// file: msio_trig_src.sv
/*
 * External trigger source: drives the trigger pin as a remote instrument.
 * Assumes the bench calls set_level; the pin idles low.
 */
`timescale 1ns/100ps
module msio_trig_src (
  // Pacing clock
  input  wire  pclk,
  // Trigger pin
  output logic trig_pin
);
  initial trig_pin = 1'b0;

  // Level is held until the next call, as a real pulse source would
  task set_level(input logic lvl);
    @(posedge pclk);
    trig_pin <= lvl;
  endtask
endmodule // msio_trig_src

// file: msio_top_tb.sv
/*
 * Self-checking bench for msio_top: APB host tasks, motion core pulses.
 * Assumes the trigger source model and the port checker are compiled too.
 */
`timescale 1ns/100ps
`include "msio_regs.vh"
module msio_top_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        move_started = 1'b0;
  logic        move_stopped = 1'b0;
  logic        step_tick = 1'b0;
  logic [31:0] cur_pos = 32'h0000_0000;
  logic [15:0] cur_ustep = 16'h0000;
  logic [31:0] prdata, move_pos, move_speed;
  logic [15:0] move_ustep;
  logic [7:0]  move_speed_ustep;
  logic        pready, pslverr, trig_in, move_req, move_absolute, sync_out;
  logic        idle_lvl = 1'b0;
  logic [31:0] fl [3] = '{32'h0000_0010, 32'h0000_0011, 32'h0000_0015};
  int          errors = 0;
  int          checked = 0;
  int          act_cnt = 0;
  int          req_cnt = 0;
  int          cyc = 0;

  msio_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_in(trig_in), .move_started(move_started),
    .move_stopped(move_stopped), .step_tick(step_tick), .cur_pos(cur_pos),
    .cur_ustep(cur_ustep), .move_req(move_req), .move_absolute(move_absolute),
    .move_pos(move_pos), .move_ustep(move_ustep), .move_speed(move_speed),
    .move_speed_ustep(move_speed_ustep), .sync_out(sync_out));
  msio_trig_src ext (.pclk(pclk), .trig_pin(trig_in));

  always #50 pclk = ~pclk;

  always @(posedge pclk) begin
    act_cnt <= act_cnt + int'(sync_out !== idle_lvl);
    req_cnt <= req_cnt + int'(move_req === 1'b1);
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  task final_report();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Held from setup until pready is seen high; data taken at that edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!wr) chk(prdata, e);
    if (!wr) chk({31'h0, pslverr}, {31'h0, a > `MSIO_OFS_STATUS});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Stage a settings group, its checksum (optionally spoilt), then the command
  task grp(input logic [7:0] base, input int n, input logic [31:0] v [6],
           input logic [31:0] code, input logic [15:0] bad);
    logic [15:0] cs;
    cs = bad;
    for (int i = 0; i < n; i++) begin
      apb(1'b1, base + 8'(4 * i), v[i], 0);
      cs ^= v[i][31:16] ^ v[i][15:0];
    end
    apb(1'b1, `MSIO_OFS_CHECKSUM, {16'h0000, cs}, 0);
    apb(1'b1, `MSIO_OFS_COMMAND, code, 0);
  endtask

  task so(input logic [31:0] f, ln, iv, wn, input logic [15:0] bad);
    grp(`MSIO_OFS_OUT_FLAGS, 5, '{f, ln, iv, wn, 0, 0}, `MSIO_CMD_SET_OUT, bad);
  endtask

  task si(input logic [31:0] f, dt, ps, us, sp, su);
    grp(`MSIO_OFS_IN_FLAGS, 6, '{f, dt, ps, us, sp, su}, `MSIO_CMD_SET_IN, 16'h0000);
  endtask

  task fire(input logic [2:0] m, input int gap);
    @(posedge pclk);
    {move_started, move_stopped, step_tick} <= m;
    @(posedge pclk);
    {move_started, move_stopped, step_tick} <= 3'b000;
    repeat (gap) @(posedge pclk);
  endtask

  task ev_cnt(input logic [2:0] m, input int n, input int gap, input int exp);
    int a0;
    repeat (2) @(posedge pclk);
    a0 = act_cnt;
    repeat (n) fire(m, gap);
    chk(32'(act_cnt - a0), 32'(exp));
  endtask

  task edge_chk(input int r1, input int r2);
    ext.set_level(1'b1);
    repeat (10) @(posedge pclk);
    chk(32'(req_cnt), 32'(r1));
    ext.set_level(1'b0);
    repeat (10) @(posedge pclk);
    chk(32'(req_cnt), 32'(r2));
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(sync_out, 0);
    for (int i = 0; i < 13; i++) apb(1'b0, 8'(4 * i), 0, 0);
    apb(1'b0, 8'h38, 0, 0);
    so(32'h0000_0002, 0, 0, 0, 16'h0000);
    apb(1'b0, `MSIO_OFS_OUT_FLAGS, 0, 32'h0000_0002);
    chk(sync_out, 1);
    so(32'h0000_0000, 0, 0, 0, 16'h0001);
    apb(1'b0, `MSIO_OFS_STATUS, 0, 32'h0000_0098);
    chk(sync_out, 1);
    for (int k = 0; k < 3; k++) begin
      so(fl[k], 2, 0, 0, 16'h0000);
      idle_lvl = (k == 2);
      ev_cnt(3'b100, 1, 40, k == 0 ? 0 : 20);
    end
    idle_lvl = 1'b0;
    so(32'h0000_0019, 3, 0, 0, 16'h0000);
    fire(3'b100, 3);
    fire(3'b001, 3);
    fire(3'b001, 3);
    chk(sync_out, 1);
    fire(3'b001, 4);
    chk(sync_out, 0);
    so(32'h0000_0041, 1, 4, 0, 16'h0000);
    ev_cnt(3'b001, 9, 15, 20);
    cur_pos <= 32'h0000_0005;
    so(32'h0000_0021, 1, 0, 2, 16'h0000);
    ev_cnt(3'b010, 1, 30, 0);
    so(32'h0000_0021, 1, 0, 6, 16'h0000);
    ev_cnt(3'b010, 1, 30, 10);
    cur_pos <= 32'h0000_000A;
    si(32'h0000_0005, 0, 32'h0000_0100, 3, 32'h0000_03E8, 7);
    edge_chk(1, 1);
    chk({move_absolute, move_pos, move_ustep}, {1'b1, 32'h0000_0100, 16'h0003});
    chk({move_speed, move_speed_ustep}, {32'h0000_03E8, 8'h07});
    cur_ustep <= 16'h0004;
    si(32'h0000_0003, 0, 32'hFFFF_FFFE, 3, 5, 0);
    edge_chk(1, 2);
    chk({move_absolute, move_pos, move_ustep}, {1'b0, 32'h0000_0008, 16'h0007});
    si(32'h0000_0000, 0, 0, 0, 0, 0);
    edge_chk(2, 2);
    si(32'h0000_0001, 3, 0, 0, 0, 0);
    edge_chk(3, 3);
    edge_chk(3, 3);
    repeat (20) @(posedge pclk);
    edge_chk(4, 4);
    final_report();
  end
endmodule // msio_top_tb
